// ### rtl/system_bus_arbitration_straps.sv
// Strap-configured system-bus arbiter with Wishbone control registers
// Function
// - Keep bus across transfers without rearbitrating
// - Drive common request waiting, sense it owning
// - Same common request handling, serial or parallel
// - Strap grounds common request: always request present
// - Takeover high: yield to lower requester
// - Takeover low: yield only via priority chain
// - Bus source, takeover low: yield higher only
// - Bus source, takeover high: yield any requester
// - Grounded source, takeover high: arbitrate per access
// - Strap enables serial priority output
// - Lock strap: assert lock during multi-transfer
// - Interrupt onto exactly one strapped line
// - Default page is lowest megabyte
// - Page strap selects highest megabyte
// - Strap terminates external terminate on board
// - Straps set option line directions
// - DMA strap routes only one connector
// - No DMA strap accepts both connectors
// - Priority input active means no higher request
// - Assert bus request while needing bus
// - Owner drives busy; none takes busy bus
// - Release common request once bus obtained
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module system_bus_arbitration_straps
  import arb_straps_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // System bus arbitration pins, active low
  input  wire logic        bprnN,
  output logic             bproN,
  output logic             breqN,
  input  wire logic        busyNIn,
  output logic             busyNOut,
  output logic             busyNOe,
  input  wire logic        cbrqNIn,
  output logic             cbrqNOut,
  output logic             cbrqNOe,
  output logic             lockN,
  output logic      [7:0]  intNOut,
  output logic      [7:0]  intNOe,
  output logic      [3:0]  commPage,
  // Expansion connectors, index 0 first, 1 second
  input  wire logic [1:0]  extTermIn,
  output logic      [1:0]  termOnBoard,
  input  wire logic [1:0]  optionZeroIn,
  output logic      [1:0]  optionZeroOut,
  output logic      [1:0]  optionZeroOe,
  input  wire logic [1:0]  optionOneIn,
  output logic      [1:0]  optionOneOut,
  output logic      [1:0]  optionOneOe,
  input  wire logic [1:0]  dmaReqIn,
  output logic             dmaReq,
  // Straps
  input  wire logic        takeover_strap,
  input  wire logic        common_request_source_strap,
  input  wire logic        serial_priority_out_strap,
  input  wire logic        lock_enable_strap,
  input  wire logic        high_page_strap,
  input  wire logic [2:0]  interrupt_line_strap,
  input  wire logic [1:0]  dma_request_route_strap,
  input  wire logic        terminate_strap_first,
  input  wire logic        terminate_strap_second,
  input  wire logic [1:0]  option_zero_direction_strap,
  input  wire logic [1:0]  option_one_direction_strap
);

  // ==========================================
  // Strap capture
  logic        strapsTaken_reg;
  logic        takeover_reg;
  logic        cbrqGround_reg;
  logic        serialOut_reg;
  logic        lockEn_reg;
  logic        highPage_reg;
  logic [2:0]  intLine_reg;
  logic [1:0]  dmaRoute_reg;
  logic [1:0]  termStrap_reg;
  logic [1:0]  opt0Dir_reg;
  logic [1:0]  opt1Dir_reg;

  // Caught once, first edge after release; reset only loads constants.
  // Moving a strap later has no effect until the next reset, so the
  // arbiter never sees its mode change under a transfer.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strapsTaken_reg <= 1'b0;
      takeover_reg    <= 1'b0;
      cbrqGround_reg  <= 1'b0;
      serialOut_reg   <= 1'b0;
      lockEn_reg      <= 1'b0;
      highPage_reg    <= 1'b0;
      intLine_reg     <= 3'h0;
      dmaRoute_reg    <= 2'h0;
      termStrap_reg   <= 2'h0;
      opt0Dir_reg     <= 2'h0;
      opt1Dir_reg     <= 2'h0;
    end else if (!strapsTaken_reg) begin
      strapsTaken_reg <= 1'b1;
      takeover_reg    <= takeover_strap;
      cbrqGround_reg  <= common_request_source_strap;
      serialOut_reg   <= serial_priority_out_strap;
      lockEn_reg      <= lock_enable_strap;
      highPage_reg    <= high_page_strap;
      intLine_reg     <= interrupt_line_strap;
      dmaRoute_reg    <= dma_request_route_strap;
      termStrap_reg   <= {terminate_strap_second, terminate_strap_first};
      opt0Dir_reg     <= option_zero_direction_strap;
      opt1Dir_reg     <= option_one_direction_strap;
    end
  end

  // ==========================================
  // Wishbone slave
  logic [7:0]  ctrl_reg;
  logic        xferDone_reg;
  logic [31:0] rdData;
  logic [9:0]  status;
  logic        wbHit;
  logic        wbWr;

  assign wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr  = wbHit & wb_we_i;

  // One-cycle answer; ack drops the cycle after it was given
  // Writes commit on the taking edge, the same edge that raises the ack
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbHit;
      wb_dat_o <= wbHit ? rdData : 32'h0000_0000;
    end
  end

  // Control register, low byte lane only
  // Writes with the low lane off leave every field as it was
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wbWr && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
      ctrl_reg <= wb_dat_i[7:0];
    end
  end

  // Any write to the transfer port marks one finished bus access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xferDone_reg <= 1'b0;
    end else begin
      xferDone_reg <= wbWr && wb_adr_i == OFS_XFER;
    end
  end

  // Read mux; unmapped offsets read zero
  // The transfer port is write only and reads zero as well
  always_comb begin
    rdData = 32'h0000_0000;
    case (wb_adr_i)
      OFS_CTRL:   rdData = {24'h000000, ctrl_reg};
      OFS_STATUS: rdData = {22'h0, status};
      OFS_STRAPS: rdData = {16'h0000, opt1Dir_reg, opt0Dir_reg,
                            termStrap_reg, dmaRoute_reg, intLine_reg,
                            highPage_reg, lockEn_reg, serialOut_reg,
                            cbrqGround_reg, takeover_reg};
      default:    rdData = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // Bus input sampling
  logic bprnAct_reg;
  logic busyOther_reg;
  logic cbrqPin_reg;
  logic otherReq;

  // Pins are bus-clock synchronous; one stage aligns them to the FSM
  // Costs one clock of grant latency, bought for a short input path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bprnAct_reg   <= 1'b0;
      busyOther_reg <= 1'b0;
      cbrqPin_reg   <= 1'b0;
    end else begin
      bprnAct_reg   <= ~bprnN;
      busyOther_reg <= ~busyNIn;
      cbrqPin_reg   <= ~cbrqNIn;
    end
  end

  // Grounded source always reads as another request
  // Own drive is sensed too, so waiting reads as a request
  assign otherReq = cbrqGround_reg | cbrqPin_reg;

  // ==========================================
  // Arbiter state machine
  arb_state_e state_reg;
  arb_state_e state_next;
  logic       want;
  logic       atBoundary;
  logic       yield;

  assign want = ctrl_reg[CTRL_WANT] & strapsTaken_reg;
  // Locked sequences are never split at a transfer end
  // Dropping want ends the lock as well, so the bus can go free
  assign atBoundary = (~want | xferDone_reg) &
                      ~(ctrl_reg[CTRL_LOCK] & lockEn_reg & want);

  // Higher master always wins via the chain; common request only
  // counts when takeover is enabled, which also covers per-access
  always_comb begin
    yield = 1'b0;
    if (!bprnAct_reg) begin
      yield = 1'b1;
    end else if (takeover_reg && otherReq) begin
      yield = 1'b1;
    end
  end

  // Next-state logic: idle, waiting for a grant, or holding the bus
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (want) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Never take the bus while another master holds busy
        if (!want) begin
          state_next = ST_IDLE;
        end else if (bprnAct_reg && !busyOther_reg) begin
          state_next = ST_OWN;
        end
      end
      ST_OWN: begin
        // Held across transfers until someone takes it away
        if (atBoundary && yield) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Arbitration pin drivers, all registered
  // Pins follow the next state so they change on the same edge as it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      breqN    <= 1'b1;
      busyNOut <= 1'b0;
      busyNOe  <= 1'b0;
      cbrqNOut <= 1'b0;
      cbrqNOe  <= 1'b0;
      bproN    <= 1'b1;
      lockN    <= 1'b1;
    end else begin
      breqN   <= ~(state_next == ST_WAIT || state_next == ST_OWN && want);
      busyNOe <= state_next == ST_OWN;
      // Driven while waiting, let go on gaining the bus
      cbrqNOe <= state_next == ST_WAIT;
      // Pass priority down only when we neither want nor hold it
      bproN   <= ~(serialOut_reg && bprnAct_reg && !want &&
                   state_next != ST_OWN);
      lockN   <= ~(lockEn_reg && ctrl_reg[CTRL_LOCK] &&
                   state_next == ST_OWN);
    end
  end

  // ==========================================
  // Interrupt line routing, open drain, one line per strap
  // The line is only ever pulled low; the level driven stays zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_int
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          intNOut[gi] <= 1'b0;
          intNOe[gi]  <= 1'b0;
        end else begin
          intNOut[gi] <= 1'b0;
          intNOe[gi]  <= ctrl_reg[CTRL_INTREQ] &&
                         intLine_reg == 3'(gi);
        end
      end
    end
  endgenerate

  // ==========================================
  // Page, expansion option and terminate outputs
  // Option outputs only reach the pin where the strap sets driving
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      commPage      <= PAGE_LOW;
      termOnBoard   <= 2'h0;
      optionZeroOut <= 2'h0;
      optionZeroOe  <= 2'h0;
      optionOneOut  <= 2'h0;
      optionOneOe   <= 2'h0;
    end else begin
      commPage      <= highPage_reg ? PAGE_HIGH : PAGE_LOW;
      termOnBoard   <= termStrap_reg;
      optionZeroOut <= ctrl_reg[CTRL_OPT0 +: 2];
      optionZeroOe  <= opt0Dir_reg;
      optionOneOut  <= ctrl_reg[CTRL_OPT1 +: 2];
      optionOneOe   <= opt1Dir_reg;
    end
  end

  // ==========================================
  // DMA request and terminate merging
  logic [1:0] dmaMask;
  logic       termActive_reg;

  // Route bit 0 keeps the second connector, bit 1 the first
  // Both bits set is treated as neither, so both lines stay accepted
  always_comb begin
    case (dmaRoute_reg)
      2'b01:   dmaMask = 2'b10;
      2'b10:   dmaMask = 2'b01;
      default: dmaMask = 2'b11;
    endcase
  end

  // Lines are ORed, so only one connector may be active at once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaReq         <= 1'b0;
      termActive_reg <= 1'b0;
    end else begin
      dmaReq         <= |(dmaReqIn & dmaMask);
      termActive_reg <= |(extTermIn & ~termStrap_reg);
    end
  end

  // ==========================================
  // Status word
  // Option inputs read zero on lines this side is driving
  assign status = {optionOneIn & ~opt1Dir_reg,
                   optionZeroIn & ~opt0Dir_reg,
                   1'b0,
                   dmaReq,
                   termActive_reg,
                   otherReq,
                   state_reg == ST_WAIT,
                   state_reg == ST_OWN};

endmodule
`default_nettype wire

// ### rtl/arb_straps_pkg.sv
// Constants for the strap-configured system-bus arbitration block
`default_nettype none
package arb_straps_pkg;
  // ==========================================
  // Register map (byte addresses)
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_STRAPS = 4'h8;
  localparam logic [3:0] OFS_XFER   = 4'hc;
  // ==========================================
  // Control field positions
  localparam int CTRL_WANT   = 0;
  localparam int CTRL_LOCK   = 1;
  localparam int CTRL_INTREQ = 2;
  localparam int CTRL_OPT0   = 4;
  localparam int CTRL_OPT1   = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ==========================================
  // Status field positions
  localparam int STAT_OWN    = 0;
  localparam int STAT_WAIT   = 1;
  localparam int STAT_OTHER  = 2;
  localparam int STAT_TERM   = 3;
  localparam int STAT_DMA    = 4;
  localparam int STAT_OPT0   = 6;
  localparam int STAT_OPT1   = 8;
  // ==========================================
  // Communication block page numbers (top address nibble)
  localparam logic [3:0] PAGE_LOW  = 4'h0;
  localparam logic [3:0] PAGE_HIGH = 4'hf;
  // ==========================================
  // Arbiter states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_OWN  = 3'b100
  } arb_state_e;
endpackage
`default_nettype wire

// ### testbench/other_bus_master.sv
// Behavioural model of the competing masters on the system bus
`timescale 1ns/1ps
`default_nettype none
module other_bus_master (
  input  wire logic sys_clk,
  input  wire logic busyNOe,
  input  wire logic cbrqNOe,
  input  wire logic higherWants,
  input  wire logic lowerWants,
  input  wire logic holdBus,
  output logic      bprnN,
  output logic      busyNIn,
  output logic      cbrqNIn
);
  logic otherBusy;
  // ====================
  // Ownership
  // Seize only a free bus, never while busy is driven
  always_ff @(posedge sys_clk) begin
    otherBusy <= holdBus && (otherBusy || !busyNOe);
  end
  // Open-collector lines with pull-ups, so released reads high
  assign busyNIn = !(busyNOe || otherBusy);
  assign cbrqNIn = !(cbrqNOe || (lowerWants && !otherBusy));
  assign bprnN = higherWants;
endmodule
`default_nettype wire

// ### testbench/arb_straps_checker.sv
// Port assertions for the system-bus arbitration block
`timescale 1ns/1ps
`default_nettype none
module arb_straps_checker
  import arb_straps_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       bprnN,
  input wire logic       breqN,
  input wire logic       busyNIn,
  input wire logic       busyNOut,
  input wire logic       busyNOe,
  input wire logic       cbrqNOut,
  input wire logic       cbrqNOe,
  input wire logic       lockN,
  input wire logic [7:0] intNOut,
  input wire logic [7:0] intNOe,
  input wire logic [3:0] commPage,
  input wire logic       lock_enable_strap,
  input wire logic       high_page_strap,
  input wire logic [2:0] interrupt_line_strap
);
  // ====================
  // Clocking and sequences
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Request, then a one-cycle answer
  sequence wbReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  // ====================
  // Assertions
  wb_ack_a: assert property (wbReq |=> ackPulse)
    else $error("ack missing or too long");
  grant_cause_a: assert property (
    $rose(busyNOe) |-> $past(busyNIn, 2) && !$past(bprnN, 2))
    else $error("bus taken while busy or without priority");
  cbrq_wait_a: assert property (
    cbrqNOe |-> !breqN && !cbrqNOut && !busyNOe)
    else $error("common request driven outside waiting");
  cbrq_release_a: assert property ($rose(busyNOe) |-> $fell(cbrqNOe))
    else $error("common request kept after grant");
  busy_drive_a: assert property ($rose(busyNOe) |-> !breqN && !busyNOut)
    else $error("grant without request or busy level wrong");
  lock_own_a: assert property (!lockN |-> busyNOe && lock_enable_strap)
    else $error("lock outside ownership or strap");
  int_line_a: assert property (
    intNOut == 8'h00 && (intNOe == 8'h00 || intNOe == 8'h01 << interrupt_line_strap))
    else $error("interrupt on wrong line");
  comm_page_a: assert property (
    $past(rst_n, 3) |-> commPage == (high_page_strap ? PAGE_HIGH : PAGE_LOW))
    else $error("wrong communication page");
endmodule
bind system_bus_arbitration_straps arb_straps_checker arb_straps_checker_inst (.*);
`default_nettype wire

// ### testbench/system_bus_arbitration_straps_tb.sv
// Self-checking bench: straps, registers and bus arbitration
`timescale 1ns/1ps
`default_nettype none
module system_bus_arbitration_straps_tb;
  import arb_straps_pkg::*;
  // ====================
  // Signals
  logic        sys_clk = 1'b0, rst_n = 1'b0, wb_ack_o, lockN, dmaReq;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hf, commPage, laneSel = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, expStat;
  logic        bprnN, bproN, breqN, busyNIn, busyNOut, busyNOe, cbrqNIn, cbrqNOut, cbrqNOe;
  logic        higherWants = 1'b0, lowerWants = 1'b0, holdBus = 1'b0;
  logic [7:0]  intNOut, intNOe, ctrl;
  logic [1:0]  extTermIn = 2'h0, optionZeroIn = 2'h0, optionOneIn = 2'h0, dmaReqIn = 2'h0;
  logic [1:0]  termOnBoard, optionZeroOut, optionZeroOe, optionOneOut, optionOneOe;
  logic [15:0] straps = 16'h0000;
  int          badCount = 0, nTests = 0;
  // ====================
  // Instances
  system_bus_arbitration_straps system_bus_arbitration_straps_inst (.*,
    .takeover_strap(straps[0]), .common_request_source_strap(straps[1]),
    .serial_priority_out_strap(straps[2]), .lock_enable_strap(straps[3]),
    .high_page_strap(straps[4]), .interrupt_line_strap(straps[7:5]),
    .dma_request_route_strap(straps[9:8]), .terminate_strap_first(straps[10]),
    .terminate_strap_second(straps[11]), .option_zero_direction_strap(straps[13:12]),
    .option_one_direction_strap(straps[15:14]));
  other_bus_master other_bus_master_inst (.*);
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  // ====================
  // Model and tasks
  function automatic logic expDma(input logic [1:0] r, input logic [1:0] d);
    return (r == 2'b01) ? d[1] : (r == 2'b10) ? d[0] : |d;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (badCount == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Straps only change under reset, as the block captures them once
  task automatic boot(input logic [15:0] s);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    straps <= s;
    higherWants <= 1'b0;
    lowerWants <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  // Classic cycle: hold until ack is sampled, then release
  task automatic wbCycle(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= laneSel;
    wb_dat_i <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    // A missing answer counts against the run
    if (wb_ack_o !== 1'b1) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic xfer();
    wbCycle(1'b1, OFS_XFER, 32'h0);
  endtask
  task automatic waitOe(input logic v);
    int n;
    n = 0;
    while (busyNOe !== v && n < 30) begin
      @(posedge sys_clk);
      n++;
    end
    cmp(busyNOe, v);
  endtask
  // ====================
  // Sequence
  initial begin
    void'($urandom(32'h1f563fe2));
    // Every interrupt line and every DMA route, other straps random
    for (int i = 0; i < 8; i++) begin
      boot((16'($urandom) & 16'hfc1f) | 16'(i << 5) | 16'((i & 3) << 8));
      dmaReqIn <= 2'($urandom);
      extTermIn <= 2'($urandom);
      optionZeroIn <= 2'($urandom);
      optionOneIn <= 2'($urandom);
      ctrl = (8'($urandom) & 8'hf4) | 8'h04;
      wbCycle(1'b1, OFS_CTRL, {24'h0, ctrl});
      wbCycle(1'b1, 4'h2, 32'hffffffff);
      // Low byte lane off: the control write must be ignored
      laneSel = 4'he;
      wbCycle(1'b1, OFS_CTRL, 32'h0);
      laneSel = 4'hf;
      wbCycle(1'b0, OFS_CTRL, 32'h0);
      cmp(rd, {24'h0, ctrl});
      wbCycle(1'b0, OFS_STRAPS, 32'h0);
      cmp(rd, {16'h0, straps});
      wbCycle(1'b0, 4'h2, 32'h0);
      cmp(rd, 32'h0);
      // Status: receive-only option lines, merged inputs, request sensed
      expStat = {22'h0, optionOneIn & ~straps[15:14], optionZeroIn & ~straps[13:12], 1'b0,
                 expDma(straps[9:8], dmaReqIn), |(extTermIn & ~straps[11:10]),
                 straps[1], 2'b00};
      wbCycle(1'b0, OFS_STATUS, 32'h0);
      cmp(rd, expStat);
      cmp(intNOe, 8'h01 << i);
      cmp(commPage, straps[4] ? PAGE_HIGH : PAGE_LOW);
      cmp({optionOneOe, optionZeroOe, termOnBoard}, straps[15:10]);
      cmp({optionOneOut, optionZeroOut}, ctrl[7:4]);
      cmp(dmaReq, expDma(straps[9:8], dmaReqIn));
      cmp(bproN, !straps[2]);
    end
    // Busy bus refused, then held until a higher master asks
    boot(16'h0004);
    holdBus <= 1'b1;
    wbCycle(1'b1, OFS_CTRL, 32'h1);
    repeat (8) @(posedge sys_clk);
    cmp({busyNOe, breqN, cbrqNIn}, 3'b000);
    holdBus <= 1'b0;
    waitOe(1'b1);
    cmp({cbrqNOe, bproN}, 2'b01);
    lowerWants <= 1'b1;
    // Watched every cycle: a wrong release would be regained at once
    repeat (2) begin
      xfer();
      repeat (4) begin
        @(posedge sys_clk);
        cmp(busyNOe, 1'b1);
      end
    end
    higherWants <= 1'b1;
    xfer();
    waitOe(1'b0);
    // Takeover on: a lower requester wins at the boundary
    boot(16'h0001);
    wbCycle(1'b1, OFS_CTRL, 32'h1);
    waitOe(1'b1);
    lowerWants <= 1'b1;
    xfer();
    waitOe(1'b0);
    // Grounded request: released and regained per access, lock blocks it
    boot(16'h000b);
    wbCycle(1'b1, OFS_CTRL, 32'h3);
    waitOe(1'b1);
    xfer();
    repeat (6) begin
      @(posedge sys_clk);
      cmp({busyNOe, lockN}, 2'b10);
    end
    wbCycle(1'b1, OFS_CTRL, 32'h1);
    xfer();
    waitOe(1'b0);
    cmp(lockN, 1'b1);
    waitOe(1'b1);
    results();
  end
  // Watchdog at more than ten times the expected run
  initial begin
    #400000;
    badCount++;
    results();
  end
endmodule
`default_nettype wire
